/* File: rtl/mpd_pkg.sv */
// Purpose: Constants and carriers for the multiuser port decode and select block.
// Assumes: Eight-bit I/O bus, 100 MHz core clock, switches static while running.
// Notes: Function
// Function
// - Respond to eight consecutive ports, base a multiple of eight.
// - Match A7..A3 against switches, on means zero; disable switch blocks all.
// - Port 0 reaches the selected channel data register.
// - Port 1 reads channel status, writes sync or printer control.
// - Port 2 reaches serial mode or parallel data register.
// - Port 3 reaches serial command or parallel status register.
// - Port 4 reads transmit interrupt status, writes transmit mask.
// - Port 5 reads receive interrupt status, writes receive mask.
// - Port 7 is write-only user select; port 6 does nothing.
// - Select bits: D1..D0 user, D2 half, D4..D3 board; D7..D5 ignored.
// - Channels answer only when board bits and half bit match switches.
// - Five select bits form the exact binary user number.
// - Selected local user gets its channel registers at channel ports.
// - Interrupt registers open when any user of this group is selected.
// - Default map: user 0 parallel, 1 loop serial, 2 middle, 3 last serial.
// - Swap option exchanges relative users 0 and 2.
// - Interrupt nibble is low for users 0-3, high for users 4-7.
// - Insert zero to three wait states on channel register accesses.
// - No wait states on user select or interrupt register accesses.
// - Reset clears all transmit and receive mask bits.
// - Mask bit n controls relative user n; one enables.

package mpd_pkg;

  localparam logic [2:0] MPD_PORT_DATA   = 3'h0;
  localparam logic [2:0] MPD_PORT_STAT   = 3'h1;
  localparam logic [2:0] MPD_PORT_MODE   = 3'h2;
  localparam logic [2:0] MPD_PORT_CMD    = 3'h3;
  localparam logic [2:0] MPD_PORT_TXINT  = 3'h4;
  localparam logic [2:0] MPD_PORT_RXINT  = 3'h5;
  localparam logic [2:0] MPD_PORT_UNUSED = 3'h6;
  localparam logic [2:0] MPD_PORT_USEL   = 3'h7;

  localparam int MPD_USER_LSB  = 0;
  localparam int MPD_USER_MSB  = 1;
  localparam int MPD_HALF_BIT  = 2;
  localparam int MPD_BOARD_LSB = 3;
  localparam int MPD_BOARD_MSB = 4;
  localparam int MPD_BASE_LSB  = 3;
  localparam int MPD_BASE_MSB  = 7;

  localparam logic [4:0] MPD_USEL_RESET = 5'h00;
  localparam logic [3:0] MPD_MASK_RESET = 4'h0;
  localparam logic [7:0] MPD_IDLE_DATA  = 8'hff;
  localparam logic [1:0] MPD_PAR_USER   = 2'h0;
  localparam logic [1:0] MPD_SWAP_USER  = 2'h2;
  localparam logic [1:0] MPD_WAIT_NONE  = 2'h0;

  typedef struct packed {
    logic [4:0] base_n;
    logic       disable_on;
    logic       half;
    logic [1:0] board;
    logic       nibble_high;
    logic       swap;
    logic [1:0] wait_count;
  } mpd_switch_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] reg_sel;
    logic [3:0] chan_onehot;
    logic [7:0] wdata;
  } mpd_chan_req_s;

  typedef enum logic [2:0] {
    MPD_IDLE = 3'b001,
    MPD_WAIT = 3'b010,
    MPD_DONE = 3'b100
  } mpd_state_e;

endpackage : mpd_pkg

/* File: rtl/mpd_top.sv */
// Purpose: Port decode, user select and interrupt nibble steering for a four user board.
// Assumes: Bus strobes are single-cycle pulses synchronous to core_clk_i.
// Notes: Channel read data is sampled at the end of the wait period.

`timescale 1ns/100ps
`default_nettype none

module mpd_top (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           bus_addr_i,
  input  wire logic                 bus_rd_i,
  input  wire logic                 bus_wr_i,
  input  wire logic [7:0]           bus_wdata_i,
  input  wire mpd_pkg::mpd_switch_s sw_i,
  input  wire logic [7:0]           chan_rdata_i,
  input  wire logic [3:0]           tx_irq_i,
  input  wire logic [3:0]           rx_irq_i,
  output logic [7:0]                bus_rdata_o,
  output logic                      bus_rdata_oe_o,
  output logic                      bus_ready_o,
  output mpd_pkg::mpd_chan_req_s    chan_req_o,
  output logic [3:0]                tx_mask_o,
  output logic [3:0]                rx_mask_o,
  output logic [4:0]                user_sel_o
);

  logic [4:0]             usel_r;
  logic [4:0]             usel_nxt;
  logic [3:0]             txm_r;
  logic [3:0]             txm_nxt;
  logic [3:0]             rxm_r;
  logic [3:0]             rxm_nxt;
  mpd_pkg::mpd_state_e    st_r;
  mpd_pkg::mpd_state_e    st_nxt;
  mpd_pkg::mpd_chan_req_s req_r;
  mpd_pkg::mpd_chan_req_s req_nxt;
  logic [7:0]             rdata_r;
  logic [7:0]             rdata_nxt;
  logic                   oe_r;
  logic                   oe_nxt;
  logic                   rdy_r;
  logic                   rdy_nxt;
  logic                   hit;
  logic                   group_hit;
  logic                   board_hit;
  logic [2:0]             port;
  logic                   chan_acc;
  logic                   wait_busy;
  logic [1:0]             phys_user;

  // A switch that is on reads as zero, so the switch level equals the address bit.
  assign hit = !sw_i.disable_on
               && (bus_addr_i[mpd_pkg::MPD_BASE_MSB:mpd_pkg::MPD_BASE_LSB] == sw_i.base_n);
  assign port = bus_addr_i[mpd_pkg::MPD_BASE_LSB-1:0];

  assign group_hit = (usel_r[mpd_pkg::MPD_BOARD_MSB:mpd_pkg::MPD_BOARD_LSB] == sw_i.board);
  assign board_hit = group_hit && (usel_r[mpd_pkg::MPD_HALF_BIT] == sw_i.half);

  // The swap option only trades which physical channel answers for users 0 and 2.
  always_comb begin
    phys_user = usel_r[mpd_pkg::MPD_USER_MSB:mpd_pkg::MPD_USER_LSB];
    if (sw_i.swap) begin
      if (phys_user == mpd_pkg::MPD_PAR_USER) begin
        phys_user = mpd_pkg::MPD_SWAP_USER;
      end else if (phys_user == mpd_pkg::MPD_SWAP_USER) begin
        phys_user = mpd_pkg::MPD_PAR_USER;
      end
    end
  end

  assign chan_acc = hit && board_hit && (port <= mpd_pkg::MPD_PORT_CMD);

  function automatic logic [3:0] onehot4(input logic [1:0] idx);
    onehot4 = 4'h1 << idx;
  endfunction

  function automatic logic [7:0] steer(input logic [3:0] nib, input logic high);
    steer = high ? {nib, 4'h0} : {4'h0, nib};
  endfunction

  function automatic logic [3:0] pick(input logic [7:0] d, input logic high);
    pick = high ? d[7:4] : d[3:0];
  endfunction

  mpd_wait_gen u_wait (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    ((st_r == mpd_pkg::MPD_IDLE) && chan_acc && (bus_rd_i || bus_wr_i)
                 && (sw_i.wait_count != mpd_pkg::MPD_WAIT_NONE)),
    .count_i    (sw_i.wait_count),
    .busy_o     (wait_busy)
  );

  always_comb begin
    usel_nxt  = usel_r;
    txm_nxt   = txm_r;
    rxm_nxt   = rxm_r;
    st_nxt    = st_r;
    req_nxt   = req_r;
    req_nxt.rd = 1'b0;
    req_nxt.wr = 1'b0;
    rdata_nxt = rdata_r;
    oe_nxt    = 1'b0;
    rdy_nxt   = 1'b1;
    unique case (st_r)
      mpd_pkg::MPD_IDLE: begin
        if (hit && bus_wr_i) begin
          unique case (port)
            mpd_pkg::MPD_PORT_USEL: begin
              usel_nxt = bus_wdata_i[mpd_pkg::MPD_BOARD_MSB:mpd_pkg::MPD_USER_LSB];
            end
            mpd_pkg::MPD_PORT_TXINT: begin
              if (group_hit) begin
                txm_nxt = pick(bus_wdata_i, sw_i.nibble_high);
              end
            end
            mpd_pkg::MPD_PORT_RXINT: begin
              if (group_hit) begin
                rxm_nxt = pick(bus_wdata_i, sw_i.nibble_high);
              end
            end
            default: begin
            end
          endcase
        end
        if (hit && bus_rd_i && group_hit) begin
          if (port == mpd_pkg::MPD_PORT_TXINT) begin
            rdata_nxt = steer(tx_irq_i, sw_i.nibble_high);
            oe_nxt    = 1'b1;
          end else if (port == mpd_pkg::MPD_PORT_RXINT) begin
            rdata_nxt = steer(rx_irq_i, sw_i.nibble_high);
            oe_nxt    = 1'b1;
          end
        end
        if (chan_acc && (bus_rd_i || bus_wr_i)) begin
          req_nxt.rd          = bus_rd_i;
          req_nxt.wr          = bus_wr_i;
          req_nxt.reg_sel     = port[1:0];
          req_nxt.chan_onehot = onehot4(phys_user);
          req_nxt.wdata       = bus_wdata_i;
          if (sw_i.wait_count != mpd_pkg::MPD_WAIT_NONE) begin
            st_nxt  = mpd_pkg::MPD_WAIT;
            rdy_nxt = 1'b0;
          end else begin
            st_nxt = mpd_pkg::MPD_DONE;
          end
        end
      end
      mpd_pkg::MPD_WAIT: begin
        rdy_nxt = 1'b0;
        if (!wait_busy) begin
          st_nxt  = mpd_pkg::MPD_DONE;
          rdy_nxt = 1'b1;
        end
      end
      mpd_pkg::MPD_DONE: begin
        if (req_r.chan_onehot != 4'h0 && st_r == mpd_pkg::MPD_DONE) begin
          rdata_nxt = chan_rdata_i;
          oe_nxt    = 1'b1;
        end
        st_nxt = mpd_pkg::MPD_IDLE;
      end
      default: begin
        st_nxt = mpd_pkg::MPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      usel_r  <= mpd_pkg::MPD_USEL_RESET;
      txm_r   <= mpd_pkg::MPD_MASK_RESET;
      rxm_r   <= mpd_pkg::MPD_MASK_RESET;
      st_r    <= mpd_pkg::MPD_IDLE;
      req_r   <= '0;
      rdata_r <= mpd_pkg::MPD_IDLE_DATA;
      oe_r    <= 1'b0;
      rdy_r   <= 1'b1;
    end else begin
      usel_r  <= usel_nxt;
      txm_r   <= txm_nxt;
      rxm_r   <= rxm_nxt;
      st_r    <= st_nxt;
      req_r   <= req_nxt;
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  // Read data is only meaningful when the enable is high; the old byte is held otherwise.
  assign bus_rdata_o    = rdata_r;
  assign bus_rdata_oe_o = oe_r;
  assign bus_ready_o    = rdy_r;
  assign chan_req_o     = req_r;
  assign tx_mask_o      = txm_r;
  assign rx_mask_o      = rxm_r;
  assign user_sel_o     = usel_r;

endmodule // mpd_top

`default_nettype wire

/* File: rtl/mpd_wait_gen.sv */
// Purpose: Counts wait states for a channel register access.
// Assumes: start pulses once per access while idle.
// Notes: Ready is low from the cycle after start until the count runs out.

`timescale 1ns/100ps
`default_nettype none

module mpd_wait_gen (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] count_i,
  output logic            busy_o
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    // Loading one less than the count lets ready rise after exactly the configured low cycles.
    if (start_i) begin
      cnt_nxt = count_i - 2'h1;
    end else if (cnt_r != mpd_pkg::MPD_WAIT_NONE) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= mpd_pkg::MPD_WAIT_NONE;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy_o = (cnt_r != mpd_pkg::MPD_WAIT_NONE);

endmodule // mpd_wait_gen

`default_nettype wire

/* File: tb/mpd_chan_model.sv */
// Purpose: Four channel register files behind the block.
// Assumes: One request pulse per access.
// Notes: Status reads give a fixed pattern per channel.
`timescale 1ns/100ps
`default_nettype none
module mpd_chan_model (
  input  wire logic                   core_clk_i,
  input  wire mpd_pkg::mpd_chan_req_s chan_req_i,
  output logic [7:0]                  chan_rdata_o
);
  logic [7:0] mem [16];
  logic [3:0] idx;
  always_comb begin
    idx = {2'h0, chan_req_i.reg_sel};
    for (int i = 0; i < 4; i++) begin
      if (chan_req_i.chan_onehot[i]) idx[3:2] = i[1:0];
    end
  end
  // A write to port one never echoes on read, so a decode slip shows.
  // Read data follows the request with no clock, since the block may take it
  // in the very cycle that the request pulse stands.
  always_comb begin
    chan_rdata_o = (idx[1:0] == 2'h1) ? {4'ha, idx} : mem[idx];
  end
  always_ff @(posedge core_clk_i) begin
    if (chan_req_i.wr) mem[idx] <= chan_req_i.wdata;
  end
endmodule // mpd_chan_model
`default_nettype wire

/* File: tb/mpd_properties.sv */
// Purpose: Concurrent checks on the ports of the decode and select block.
// Assumes: Strobes arrive only while the block is idle.
// Notes: Attached to mpd_top by the bind after the module.
`timescale 1ns/100ps
`default_nettype none
module mpd_properties (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic [7:0]             bus_addr_i,
  input wire logic                   bus_rd_i,
  input wire logic                   bus_wr_i,
  input wire logic [7:0]             bus_wdata_i,
  input wire mpd_pkg::mpd_switch_s   sw_i,
  input wire logic [3:0]             rx_irq_i,
  input wire logic [7:0]             bus_rdata_o,
  input wire logic                   bus_rdata_oe_o,
  input wire logic                   bus_ready_o,
  input wire mpd_pkg::mpd_chan_req_s chan_req_o,
  input wire logic [3:0]             tx_mask_o,
  input wire logic [3:0]             rx_mask_o,
  input wire logic [4:0]             user_sel_o
);
  logic       hit, chan, sel_ok, brd_ok;
  logic [1:0] phys, asel;
  logic [3:0] nib, rnib;
  logic [4:0] wd5;
  assign hit = (bus_rd_i | bus_wr_i) & (bus_addr_i[7:3] == sw_i.base_n) & !sw_i.disable_on;
  assign brd_ok = user_sel_o[4:3] == sw_i.board;
  assign sel_ok = brd_ok & (user_sel_o[2] == sw_i.half);
  assign chan = hit & !bus_addr_i[2];
  assign phys = (sw_i.swap & !user_sel_o[0]) ? user_sel_o[1:0] ^ 2'h2 : user_sel_o[1:0];
  assign nib = sw_i.nibble_high ? bus_wdata_i[7:4] : bus_wdata_i[3:0];
  assign rnib = sw_i.nibble_high ? bus_rdata_o[7:4] : bus_rdata_o[3:0];
  assign asel = bus_addr_i[1:0];
  assign wd5 = bus_wdata_i[4:0];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  rst_value_a: assert property ($rose(rst_n_i) |-> tx_mask_o == 4'h0 && rx_mask_o == 4'h0
    && user_sel_o == 5'h00) else $error("reset values wrong");
  usel_load_a: assert property (hit && bus_wr_i && bus_addr_i[2:0] == 3'h7
    |=> user_sel_o == $past(wd5)) else $error("user select not loaded");
  tx_mask_a: assert property (hit && bus_wr_i && bus_addr_i[2:0] == 3'h4 && brd_ok
    |=> tx_mask_o == $past(nib)) else $error("transmit mask wrong");
  rx_status_a: assert property (hit && bus_rd_i && bus_addr_i[2:0] == 3'h5 && brd_ok
    |=> bus_rdata_oe_o && rnib == $past(rx_irq_i)) else $error("receive status wrong");
  chan_req_a: assert property (chan && sel_ok |=> chan_req_o.rd == $past(bus_rd_i)
    && chan_req_o.wr == $past(bus_wr_i) && chan_req_o.reg_sel == $past(asel)
    && chan_req_o.chan_onehot == 4'h1 << $past(phys)) else $error("channel request wrong");
  chan_refuse_a: assert property (chan && !sel_ok |=> !chan_req_o.rd && !chan_req_o.wr
    ##1 !bus_rdata_oe_o) else $error("unselected channel answered");
  block_miss_a: assert property ((bus_rd_i || bus_wr_i) && !hit |=> !bus_rdata_oe_o
    && !chan_req_o.rd && !chan_req_o.wr && $stable(user_sel_o)) else $error("miss answered");
  dead_port_a: assert property (hit && bus_rd_i && bus_addr_i[2:1] == 2'h3
    |=> !bus_rdata_oe_o [*3]) else $error("dead port answered");
  no_wait_a: assert property (hit && bus_addr_i[2] |=> bus_ready_o [*3])
    else $error("wait on fast port");
  zero_wait_a: assert property (chan && sel_ok && sw_i.wait_count == 2'h0
    |=> bus_ready_o [*2]) else $error("wait with none set");
  chan_wait_a: assert property (chan && sel_ok && sw_i.wait_count != 2'h0
    |=> !bus_ready_o ##[1:6] bus_ready_o) else $error("wait states wrong");
  cover property (chan && sel_ok && bus_rd_i);
  cover property (hit && bus_wr_i && bus_addr_i[2:0] == 3'h7);
  cover property (chan && !sel_ok);
endmodule // mpd_properties
bind mpd_top mpd_properties mpd_properties_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
  .sw_i(sw_i), .rx_irq_i(rx_irq_i), .bus_rdata_o(bus_rdata_o), .bus_rdata_oe_o(bus_rdata_oe_o),
  .bus_ready_o(bus_ready_o), .chan_req_o(chan_req_o), .tx_mask_o(tx_mask_o),
  .rx_mask_o(rx_mask_o), .user_sel_o(user_sel_o));
`default_nettype wire

/* File: tb/test_mpd_top.sv */
// Purpose: Register level tests of the decode and select block.
// Assumes: Board at ports 10h to 17h as users 4 to 7.
// Notes: Each access is given a fixed window long enough for three waits.
`timescale 1ns/100ps
`default_nettype none
module test_mpd_top;
  logic                   clk, rst_n, rd, wr, g, oe, rdy;
  logic [7:0]             a, d, q, rq, rdat;
  logic [3:0]             txi, rxi, txm, rxm;
  logic [4:0]             us, bs;
  logic [1:0]             ph;
  logic [7:0]             v;
  mpd_pkg::mpd_switch_s   sw;
  mpd_pkg::mpd_chan_req_s req;
  int                     errors, checks_done, nw;
  mpd_top mpd_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .bus_addr_i(a), .bus_rd_i(rd),
    .bus_wr_i(wr), .bus_wdata_i(d), .sw_i(sw), .chan_rdata_i(rdat), .tx_irq_i(txi),
    .rx_irq_i(rxi), .bus_rdata_o(rq), .bus_rdata_oe_o(oe), .bus_ready_o(rdy),
    .chan_req_o(req), .tx_mask_o(txm), .rx_mask_o(rxm), .user_sel_o(us));
  mpd_chan_model mpd_chan_model_i (.core_clk_i(clk), .chan_req_i(req), .chan_rdata_o(rdat));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] p, input logic [7:0] val);
    @(negedge clk);
    a = {bs, p};
    d = val;
    rd = !w;
    wr = w;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    g = 1'b0;
    nw = 0;
    repeat (12) begin
      if (oe === 1'b1) g = 1'b1;
      if (oe === 1'b1) q = rq;
      if (rdy !== 1'b1) nw++;
      @(negedge clk);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    {rst_n, rd, wr, a, d, bs, txi, rxi} = {3'h0, 16'h0000, 5'h02, 8'h96};
    sw = {5'h02, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 2'h0};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({txm, rxm}, 8'h00);
    chk({3'h0, us}, 8'h00);
    acc(1'b0, 3'h7, 8'h00);
    chk({7'h00, g}, 8'h00);
    acc(1'b0, 3'h6, 8'h00);
    chk({7'h00, g}, 8'h00);
    acc(1'b1, 3'h7, 8'he5);
    chk({3'h0, us}, 8'h05);
    acc(1'b1, 3'h4, 8'h3c);
    chk({4'h0, txm}, 8'h03);
    acc(1'b1, 3'h5, 8'hf0);
    acc(1'b0, 3'h5, 8'h00);
    chk({rxm, q[7:4]}, {4'hf, rxi});
    acc(1'b0, 3'h4, 8'h00);
    chk(q, {txi, 4'h0});
    sw.nibble_high = 1'b0;
    acc(1'b1, 3'h4, 8'h3c);
    chk({4'h0, txm}, 8'h0c);
    sw.nibble_high = 1'b1;
    for (int w = 0; w < 4; w++) begin
      for (int s = 0; s < 2; s++) begin
        sw.wait_count = w[1:0];
        sw.swap = s[0];
        for (int u = 0; u < 4; u++) begin
          acc(1'b1, 3'h7, {6'h01, u[1:0]});
          ph = (s == 1 && u[0] == 1'b0) ? u[1:0] ^ 2'h2 : u[1:0];
          for (int p = 0; p < 4; p++) begin
            v = {w[1:0], s[0], u[1:0], p[2:0]};
            acc(1'b1, p[2:0], v);
            chk(nw[7:0], {6'h00, w[1:0]});
            acc(1'b0, p[2:0], 8'h00);
            chk(q, (p == 1) ? {4'ha, ph, 2'h1} : v);
          end
        end
      end
    end
    acc(1'b1, 3'h7, 8'h00);
    chk(nw[7:0], 8'h00);
    acc(1'b1, 3'h4, 8'h50);
    chk({4'h0, txm}, 8'h05);
    chk(nw[7:0], 8'h00);
    acc(1'b0, 3'h0, 8'h00);
    chk({7'h00, g}, 8'h00);
    acc(1'b1, 3'h7, 8'h0c);
    acc(1'b1, 3'h4, 8'ha0);
    chk({4'h0, txm}, 8'h05);
    sw.disable_on = 1'b1;
    acc(1'b1, 3'h7, 8'h07);
    chk({3'h0, us}, 8'h0c);
    sw.disable_on = 1'b0;
    bs = 5'h03;
    acc(1'b1, 3'h7, 8'h07);
    chk({3'h0, us}, 8'h0c);
    bs = 5'h02;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({txm, rxm, 3'h0, us}, 16'h0000);
    finish_test;
  end
endmodule // test_mpd_top
`default_nettype wire
